// File: design/ialc_core.sv
`timescale 1ns/1ns
`include "ialc_defs.svh"
module ialc_core #(
	parameter int ATK_NORM_CYC = `IALC_ATK_NORM_CYC,
	parameter int ATK_LIM_CYC = `IALC_ATK_LIM_CYC,
	parameter int DCY_NORM_CYC = `IALC_DCY_NORM_CYC,
	parameter int DCY_LIM_CYC = `IALC_DCY_LIM_CYC,
	parameter int HOLD_BASE_CYC = `IALC_HOLD_BASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ialc_pkg::ialc_sample_t sample_in,
	output logic [5:0] amp_gain,
	output logic amp_mute
);
	import ialc_pkg::*;

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int CNT_W = 28;
	// Full-scale magnitude for each target code, -22.5dBFS upward in 1.5dB; codes 14 and 15 are both -1.5dBFS
	localparam logic [15:0] TARGET_AMP [16] = '{
		16'h0999, 16'h0B68, 16'h0D8F, 16'h101D, 16'h1327, 16'h16C3, 16'h1B0D, 16'h2027,
		16'h2636, 16'h2D6A, 16'h35FA, 16'h4027, 16'h4C3E, 16'h5A9D, 16'h6BB2, 16'h6BB2
	};
	localparam logic [CNT_W-1:0] ATK_N = CNT_W'(ATK_NORM_CYC);
	localparam logic [CNT_W-1:0] ATK_L = CNT_W'(ATK_LIM_CYC);
	localparam logic [CNT_W-1:0] DCY_N = CNT_W'(DCY_NORM_CYC);
	localparam logic [CNT_W-1:0] DCY_L = CNT_W'(DCY_LIM_CYC);
	localparam logic [CNT_W-1:0] HOLD_B = CNT_W'(HOLD_BASE_CYC);
	localparam ialc_cfg_t CFG_RST = '{
		min_gain_limit: `IALC_RST_MIN,
		max_gain_limit: `IALC_RST_MAX,
		target_level: `IALC_RST_TARGET,
		hold_time: `IALC_RST_HOLD,
		decay_time: `IALC_RST_DECAY,
		attack_time: `IALC_RST_ATTACK,
		input_amp_mute: `IALC_RST_MUTE,
		default: '0
	};
	localparam ialc_st_t ST_RST = '{
		cfg: CFG_RST,
		fsm: ST_OFF,
		loop_gain: `IALC_RST_GAIN,
		start_gain: `IALC_RST_GAIN,
		out_gain: `IALC_RST_GAIN,
		default: '0
	};

	ialc_st_t q;
	ialc_st_t d;
	logic [15:0] abs_s;
	logic over_now;
	logic zx;
	logic en;
	logic setup;
	logic access;
	logic [9:0] widx;
	logic [5:0] min_code;
	logic [5:0] max_code;
	logic [5:0] cap_base;
	logic [5:0] cap;
	logic [5:0] gain_up;
	logic [5:0] gain_dn;
	logic [CNT_W-1:0] cnt_inc;
	logic [CNT_W-1:0] atk_lim;
	logic [CNT_W-1:0] dcy_lim;
	logic [CNT_W-1:0] hold_lim;

	// Interval for a rate code; codes above the ceiling all give the longest
	function automatic logic [CNT_W-1:0] step_lim(input logic [CNT_W-1:0] base, input logic [3:0] code);
		logic [3:0] c;
		c = (code > `IALC_CODE_SAT) ? `IALC_CODE_SAT : code;
		step_lim = base << c;
	endfunction

	// Hold length: code zero means no hold at all
	function automatic logic [CNT_W-1:0] hold_len(input logic [CNT_W-1:0] base, input logic [3:0] code);
		logic [3:0] c;
		c = (code > `IALC_CODE_SAT) ? `IALC_CODE_SAT : code;
		hold_len = (c == 4'h0) ? '0 : base << 4'(c - 4'h1);
	endfunction

	// ----------------------------------------
	// Peak detector and derived limits
	// ----------------------------------------
	// Magnitude of the sample; the most negative value maps to 0x8000
	assign abs_s = sample_in.data[15] ? 16'(~sample_in.data + 16'h0001) : sample_in.data;
	assign over_now = sample_in.valid && (abs_s > TARGET_AMP[q.cfg.target_level]);
	assign zx = sample_in.valid && (sample_in.data[15] != q.last_sign);
	assign en = q.cfg.level_loop_enable;
	// Gain codes are 0.75dB apart, so a 6dB field step is eight codes
	assign min_code = {q.cfg.min_gain_limit, `IALC_MIN_FILL};
	assign max_code = {q.cfg.max_gain_limit, `IALC_MAX_FILL};
	// On the enabling cycle the start level is the gain being taken over
	assign cap_base = (q.fsm == ST_OFF) ? q.loop_gain : q.start_gain;
	assign cap = (q.cfg.limiter_mode_select && cap_base < max_code) ? cap_base : max_code;
	assign gain_up = (q.loop_gain < cap) ? 6'(q.loop_gain + 6'h01) : q.loop_gain;
	assign gain_dn = (q.loop_gain > min_code) ? 6'(q.loop_gain - 6'h01) : q.loop_gain;
	assign cnt_inc = CNT_W'(q.cnt + 1'b1);
	// Mode picks the base period of both rates
	assign atk_lim = step_lim(q.cfg.limiter_mode_select ? ATK_L : ATK_N, q.cfg.attack_time);
	assign dcy_lim = step_lim(q.cfg.limiter_mode_select ? DCY_L : DCY_N, q.cfg.decay_time);
	assign hold_lim = hold_len(HOLD_B, q.cfg.hold_time);

	// Bus phases; a request is taken only in the cycle after its setup
	assign setup = psel && !penable;
	assign access = psel && penable && q.pready;
	assign widx = paddr[11:2];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.pready = setup;
		if (sample_in.valid) begin
			d.last_sign = sample_in.data[15];
			if (abs_s > q.peak) begin
				d.peak = abs_s;
			end
		end
		// Set before any clear below, which then keeps a new event
		if (over_now) begin
			d.over = 1'b1;
		end

		// Read data is latched at setup so it leaves a flop
		if (setup) begin
			d.prdata = '0;
			d.pslverr = 1'b0;
			if (widx == `IALC_IDX_GAIN_LIMITS) begin
				d.prdata[`IALC_MIN_LSB +: 3] = q.cfg.min_gain_limit;
				d.prdata[`IALC_MAX_LSB +: 3] = q.cfg.max_gain_limit;
				d.prdata[`IALC_EN_BIT] = q.cfg.level_loop_enable;
			end else if (widx == `IALC_IDX_TARGET_HOLD) begin
				d.prdata[`IALC_TARGET_LSB +: 4] = q.cfg.target_level;
				d.prdata[`IALC_HOLD_LSB +: 4] = q.cfg.hold_time;
			end else if (widx == `IALC_IDX_MODE_TIMING) begin
				d.prdata[`IALC_MODE_BIT] = q.cfg.limiter_mode_select;
				d.prdata[`IALC_DECAY_LSB +: 4] = q.cfg.decay_time;
				d.prdata[`IALC_ATTACK_LSB +: 4] = q.cfg.attack_time;
			end else if (widx == `IALC_IDX_ZERO_CROSS) begin
				d.prdata[`IALC_ZC_BIT] = q.cfg.zero_cross_update;
			end else if (widx == `IALC_IDX_AMP_GAIN) begin
				// Live loop gain, so software can follow the regulation
				d.prdata[`IALC_GAIN_LSB +: 6] = q.loop_gain;
				d.prdata[`IALC_MUTE_BIT] = q.cfg.input_amp_mute;
			end else if (widx == `IALC_IDX_STATUS) begin
				d.prdata[`IALC_ST_FSM_LSB +: 4] = q.fsm;
				d.prdata[`IALC_ST_OVER_BIT] = q.over;
				d.prdata[`IALC_ST_PEAK_LSB +: 8] = q.peak[15:8];
			end else begin
				d.pslverr = 1'b1;
			end
		end

		// Register writes land at the access edge
		if (access && pwrite) begin
			if (widx == `IALC_IDX_GAIN_LIMITS) begin
				d.cfg.min_gain_limit = pwdata[`IALC_MIN_LSB +: 3];
				d.cfg.max_gain_limit = pwdata[`IALC_MAX_LSB +: 3];
				d.cfg.level_loop_enable = pwdata[`IALC_EN_BIT];
			end else if (widx == `IALC_IDX_TARGET_HOLD) begin
				d.cfg.target_level = pwdata[`IALC_TARGET_LSB +: 4];
				d.cfg.hold_time = pwdata[`IALC_HOLD_LSB +: 4];
			end else if (widx == `IALC_IDX_MODE_TIMING) begin
				d.cfg.limiter_mode_select = pwdata[`IALC_MODE_BIT];
				d.cfg.decay_time = pwdata[`IALC_DECAY_LSB +: 4];
				d.cfg.attack_time = pwdata[`IALC_ATTACK_LSB +: 4];
				// Switching into limiter mode freezes the current gain as ceiling
				if (pwdata[`IALC_MODE_BIT] && !q.cfg.limiter_mode_select) begin
					d.start_gain = q.loop_gain;
				end
			end else if (widx == `IALC_IDX_ZERO_CROSS) begin
				d.cfg.zero_cross_update = pwdata[`IALC_ZC_BIT];
			end else if (widx == `IALC_IDX_AMP_GAIN) begin
				d.cfg.input_amp_mute = pwdata[`IALC_MUTE_BIT];
				// A gain write while the loop owns the gain would fight it
				if (q.fsm == ST_OFF && !en) begin
					d.loop_gain = pwdata[`IALC_GAIN_LSB +: 6];
				end
			end
		end

		// Gain loop
		if (!en) begin
			d.fsm = ST_OFF;
		end else begin
			case (q.fsm)
				ST_OFF: begin
					// A zero hold skips the hold state, so no cycle is lost before decay
					d.fsm = (hold_lim == '0) ? ST_DECAY : ST_HOLD;
					d.cnt = '0;
					d.over = over_now;
					d.start_gain = q.loop_gain;
				end
				ST_HOLD: begin
					if (q.over || over_now) begin
						d.fsm = ST_ATTACK;
						d.cnt = '0;
					end else if (cnt_inc >= hold_lim) begin
						d.fsm = ST_DECAY;
						d.cnt = '0;
					end else begin
						d.cnt = cnt_inc;
					end
				end
				ST_DECAY: begin
					if (q.over || over_now) begin
						d.fsm = ST_ATTACK;
						d.cnt = '0;
					end else if (cnt_inc >= dcy_lim) begin
						d.loop_gain = gain_up;
						d.cnt = '0;
						d.peak = '0;
					end else begin
						d.cnt = cnt_inc;
					end
				end
				ST_ATTACK: begin
					if (cnt_inc >= atk_lim) begin
						d.cnt = '0;
						d.peak = '0;
						if (q.over || over_now) begin
							d.loop_gain = gain_dn;
							d.over = over_now;
						end else begin
							d.fsm = (hold_lim == '0) ? ST_DECAY : ST_HOLD;
						end
					end else begin
						d.cnt = cnt_inc;
					end
				end
				default: begin
					d.fsm = ST_OFF;
				end
			endcase
		end

		// Keep the running gain inside the window; minimum wins a conflict
		if (d.fsm != ST_OFF) begin
			if (d.loop_gain > cap) begin
				d.loop_gain = cap;
			end
			if (d.loop_gain < min_code) begin
				d.loop_gain = min_code;
			end
		end

		// While the loop runs, pending changes wait for a sign change to avoid zipper clicks
		if (!d.cfg.zero_cross_update || d.fsm == ST_OFF || zx) begin
			d.out_gain = d.loop_gain;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= ST_RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// Outputs straight from the state flops
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign amp_gain = q.out_gain;
	assign amp_mute = q.cfg.input_amp_mute;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_gain_floor: assert property (
		q.fsm != ST_OFF && $past(q.fsm) != ST_OFF && q.cfg == $past(q.cfg) |-> q.loop_gain >= min_code
	) else $error("loop gain under minimum");

	a_gain_ceiling: assert property (
		q.fsm != ST_OFF && $past(q.fsm) != ST_OFF && q.cfg == $past(q.cfg) && min_code <= max_code
		|-> q.loop_gain <= max_code
	) else $error("loop gain over maximum");

	a_limiter_cap: assert property (
		q.fsm != ST_OFF && $past(q.fsm) != ST_OFF && q.cfg.limiter_mode_select && q.cfg == $past(q.cfg)
		&& q.start_gain == $past(q.start_gain) && q.start_gain >= min_code |-> q.loop_gain <= q.start_gain
	) else $error("limiter raised gain past start level");

	a_one_step: assert property (
		q.fsm != ST_OFF && $past(q.fsm) != ST_OFF && q.cfg == $past(q.cfg) && q.cfg == $past(q.cfg, 2)
		|-> q.loop_gain == $past(q.loop_gain) || q.loop_gain == 6'($past(q.loop_gain) + 6'h01)
		|| 6'(q.loop_gain + 6'h01) == $past(q.loop_gain)
	) else $error("gain moved more than one step");

	a_raise_below: assert property (
		q.loop_gain > $past(q.loop_gain) && $past(q.fsm) != ST_OFF && q.fsm != ST_OFF
		&& q.cfg == $past(q.cfg) && q.cfg == $past(q.cfg, 2)
		|-> $past(q.fsm) == ST_DECAY && !$past(q.over || over_now)
	) else $error("gain raised outside decay");

	a_lower_above: assert property (
		q.loop_gain < $past(q.loop_gain) && $past(q.fsm) != ST_OFF && q.fsm != ST_OFF
		&& q.cfg == $past(q.cfg) && q.cfg == $past(q.cfg, 2)
		|-> $past(q.fsm) == ST_ATTACK && $past(q.over || over_now)
	) else $error("gain lowered without a peak");

	a_decay_interval: assert property (
		$past(q.fsm) == ST_DECAY && q.loop_gain > $past(q.loop_gain) |-> $past(cnt_inc) >= $past(dcy_lim)
	) else $error("gain raised before decay interval");

	a_attack_interval: assert property (
		$past(q.fsm) == ST_ATTACK && q.loop_gain < $past(q.loop_gain) && q.fsm != ST_OFF
		&& q.cfg == $past(q.cfg) |-> $past(cnt_inc) >= $past(atk_lim)
	) else $error("gain lowered before attack interval");

	a_hold_wait: assert property (
		$past(q.fsm) == ST_HOLD && q.fsm == ST_DECAY |-> $past(cnt_inc) >= $past(hold_lim)
	) else $error("decay began before hold time");

	a_disable_off: assert property (
		!en && clk_en |=> q.fsm == ST_OFF
	) else $error("loop active while disabled");

	a_disabled_keep: assert property (
		$past(q.fsm) == ST_OFF && q.fsm == ST_OFF && !$past(access && pwrite) |-> $stable(q.loop_gain)
	) else $error("gain drifted while disabled");

	a_zc_apply: assert property (
		$changed(q.out_gain) && q.cfg.zero_cross_update && q.fsm != ST_OFF |-> $past(zx)
	) else $error("gain applied away from a zero crossing");

endmodule // ialc_core

// File: shared/ialc_defs.svh
`ifndef IALC_DEFS_SVH
`define IALC_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IALC_IDX_GAIN_LIMITS 10'h020
`define IALC_IDX_TARGET_HOLD 10'h021
`define IALC_IDX_MODE_TIMING 10'h022
`define IALC_IDX_ZERO_CROSS 10'h02A
`define IALC_IDX_AMP_GAIN 10'h02D
`define IALC_IDX_STATUS 10'h02E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IALC_MIN_LSB 0
`define IALC_MAX_LSB 3
`define IALC_EN_BIT 8
`define IALC_TARGET_LSB 0
`define IALC_HOLD_LSB 4
`define IALC_MODE_BIT 8
`define IALC_DECAY_LSB 4
`define IALC_ATTACK_LSB 0
`define IALC_ZC_BIT 1
`define IALC_GAIN_LSB 0
`define IALC_MUTE_BIT 6
`define IALC_ST_FSM_LSB 0
`define IALC_ST_OVER_BIT 4
`define IALC_ST_PEAK_LSB 8

// ----------------------------------------
// Reset values and gain code mapping
// ----------------------------------------
`define IALC_RST_MIN 3'h0
`define IALC_RST_MAX 3'h7
`define IALC_RST_TARGET 4'hB
`define IALC_RST_HOLD 4'h0
`define IALC_RST_DECAY 4'h3
`define IALC_RST_ATTACK 4'h2
`define IALC_RST_GAIN 6'h10
`define IALC_RST_MUTE 1'h1
`define IALC_MIN_FILL 3'h0
`define IALC_MAX_FILL 3'h7
`define IALC_CODE_SAT 4'hA

// ----------------------------------------
// Timing
// ----------------------------------------
`define IALC_CLK_PERIOD_NS 20
`define IALC_ATK_NORM_NS 104000
`define IALC_ATK_LIM_NS 22700
`define IALC_DCY_NORM_NS 410000
`define IALC_DCY_LIM_NS 90800
`define IALC_HOLD_BASE_NS 2670000
`define IALC_ATK_NORM_CYC (`IALC_ATK_NORM_NS / `IALC_CLK_PERIOD_NS)
`define IALC_ATK_LIM_CYC (`IALC_ATK_LIM_NS / `IALC_CLK_PERIOD_NS)
`define IALC_DCY_NORM_CYC (`IALC_DCY_NORM_NS / `IALC_CLK_PERIOD_NS)
`define IALC_DCY_LIM_CYC (`IALC_DCY_LIM_NS / `IALC_CLK_PERIOD_NS)
`define IALC_HOLD_BASE_CYC (`IALC_HOLD_BASE_NS / `IALC_CLK_PERIOD_NS)

`endif

// File: shared/ialc_pkg.sv
package ialc_pkg;

	// Loop states, one-hot
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_HOLD = 4'h2,
		ST_DECAY = 4'h4,
		ST_ATTACK = 4'h8
	} ialc_fsm_t;

	// One audio sample with its strobe
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} ialc_sample_t;

	// Software settings
	typedef struct packed {
		logic [2:0] min_gain_limit;
		logic [2:0] max_gain_limit;
		logic level_loop_enable;
		logic [3:0] target_level;
		logic [3:0] hold_time;
		logic limiter_mode_select;
		logic [3:0] decay_time;
		logic [3:0] attack_time;
		logic zero_cross_update;
		logic input_amp_mute;
	} ialc_cfg_t;

	// Whole state of the block
	typedef struct packed {
		ialc_cfg_t cfg;
		ialc_fsm_t fsm;
		logic [27:0] cnt;
		logic over;
		logic [15:0] peak;
		logic [5:0] loop_gain;
		logic [5:0] start_gain;
		logic [5:0] out_gain;
		logic last_sign;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ialc_st_t;

endpackage

// File: verif/ialc_amp_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Input amplifier and converter stand-in
// ----------------------------------------
module ialc_amp_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic amp_mute,
	input wire logic [15:0] level,
	input wire logic flip,
	output ialc_pkg::ialc_sample_t sample_in
);
	import ialc_pkg::*;
	logic odd_q;
	logic neg_q;
	logic [15:0] val;

	// Muted amplifier gives silence; gain is folded into level by the bench
	assign val = amp_mute ? 16'h0000 : (neg_q ? -level : level);

	// One sample every second cycle; data scrambled between strobes so stale values never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odd_q <= 1'b0;
			neg_q <= 1'b0;
			sample_in <= '0;
		end else begin
			odd_q <= !odd_q;
			sample_in.valid <= odd_q;
			sample_in.data <= odd_q ? val : ~val;
			// Sign alternates only when asked, so zero crossings are controllable
			if (odd_q && flip) begin
				neg_q <= !neg_q;
			end
		end
	end
endmodule // ialc_amp_model

// File: verif/testbench.sv
`timescale 1ns/1ns
`include "ialc_defs.svh"
module testbench;
	import ialc_pkg::*;
	localparam logic [11:0] adr_lim = {`IALC_IDX_GAIN_LIMITS, 2'b00};
	localparam logic [11:0] adr_tgt = {`IALC_IDX_TARGET_HOLD, 2'b00};
	localparam logic [11:0] adr_mod = {`IALC_IDX_MODE_TIMING, 2'b00};
	localparam logic [11:0] adr_zc = {`IALC_IDX_ZERO_CROSS, 2'b00};
	localparam logic [11:0] adr_amp = {`IALC_IDX_AMP_GAIN, 2'b00};
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, amp_mute, flip, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] level;
	logic [5:0] amp_gain;
	ialc_sample_t sample_in;
	int errors, total_checks, c, t0, t1;

	// ----------------------------------------
	// Design and far side
	// ----------------------------------------
	ialc_core #(.ATK_NORM_CYC(4), .ATK_LIM_CYC(2), .DCY_NORM_CYC(8), .DCY_LIM_CYC(3), .HOLD_BASE_CYC(16)) DUT (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_in(sample_in), .amp_gain(amp_gain), .amp_mute(amp_mute));
	ialc_amp_model amp (.pclk(pclk), .presetn(presetn), .amp_mute(amp_mute), .level(level), .flip(flip),
		.sample_in(sample_in));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for pready however long it takes
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		check(rd, exp);
	endtask

	// Cycles until the gain moves, or lim if it never does
	task wait_step(input int lim, output int n);
		logic [5:0] g;
		g = amp_gain;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (amp_gain === g && n < lim);
	endtask

	// Skip steps until one goes the wanted way, so later intervals are clean
	task step_until(input logic up);
		logic [5:0] g0;
		int n;
		do begin
			g0 = amp_gain;
			wait_step(32'h3E8, n);
		end while ((up ? amp_gain > g0 : amp_gain < g0) !== 1'b1);
	endtask

	task results;
		$display("errors=%0d checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Cuts a hang short; the whole run needs well under this
	initial begin
		#1000000;
		errors++;
		results;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{clk_en, presetn, psel, penable, pwrite, flip} = 6'h21;
		paddr = 12'h000;
		pwdata = 32'h0;
		level = 16'h0100;
		errors = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(adr_lim, 32'h38);
		rd_chk(adr_tgt, 32'h0B);
		rd_chk(adr_mod, 32'h32);
		rd_chk(adr_zc, 32'h0);
		rd_chk(adr_amp, 32'h50);
		check(amp_gain, 32'h10);
		apb(12'h0C0, 1'b0, 32'h0);
		check({31'h0, er}, 32'h1);
		// Normal decay up to the cap; mute cleared before enabling
		apb(adr_amp, 1'b1, 32'h10);
		apb(adr_mod, 1'b1, 32'h0);
		check(amp_mute, 32'h0);
		apb(adr_lim, 1'b1, 32'h110);
		wait_step(32'h3E8, t0);
		check(amp_gain, 32'h11);
		wait_step(32'h3E8, c);
		check(c, 32'h8);
		repeat (5) wait_step(32'h3E8, c);
		check(amp_gain, 32'h17);
		wait_step(32'hC8, c);
		check(c, 32'hC8);
		// Disabled loop keeps its gain until software writes one
		apb(adr_lim, 1'b1, 32'h010);
		wait_step(32'h64, c);
		check(c, 32'h64);
		apb(adr_amp, 1'b1, 32'h12);
		apb(adr_tgt, 1'b1, 32'h1B);
		apb(adr_mod, 1'b1, 32'h10);
		check(amp_gain, 32'h12);
		// Hold code 1 and decay code 1 lengthen the first step
		apb(adr_lim, 1'b1, 32'h110);
		wait_step(32'h3E8, t1);
		check(32'(t1 - t0), 32'h18);
		wait_step(32'h3E8, c);
		check(c, 32'h10);
		// Attack down to the floor
		apb(adr_mod, 1'b1, 32'h0);
		apb(adr_lim, 1'b1, 32'h111);
		level <= 16'h7000;
		step_until(1'b0);
		wait_step(32'h3E8, c);
		check(c, 32'h4);
		for (int i = 0; i < 20 && amp_gain !== 6'h08; i++) wait_step(32'h64, c);
		wait_step(32'hC8, c);
		check(c, 32'hC8);
		check(amp_gain, 32'h8);
		// Limiter never climbs past its starting gain
		level <= 16'h0100;
		apb(adr_lim, 1'b1, 32'h038);
		apb(adr_amp, 1'b1, 32'h14);
		apb(adr_mod, 1'b1, 32'h100);
		apb(adr_tgt, 1'b1, 32'h0B);
		apb(adr_lim, 1'b1, 32'h138);
		wait_step(32'h12C, c);
		check(c, 32'h12C);
		level <= 16'h7000;
		step_until(1'b0);
		wait_step(32'h3E8, c);
		check(c, 32'h2);
		level <= 16'h0100;
		step_until(1'b1);
		wait_step(32'h3E8, c);
		check(c, 32'h3);
		for (int i = 0; i < 8 && amp_gain !== 6'h14; i++) wait_step(32'h64, c);
		wait_step(32'h12C, c);
		check(amp_gain, 32'h14);
		// Zero-cross gating holds changes until the sign flips
		apb(adr_lim, 1'b1, 32'h038);
		flip <= 1'b0;
		apb(adr_mod, 1'b1, 32'h0);
		apb(adr_zc, 1'b1, 32'h2);
		apb(adr_amp, 1'b1, 32'h10);
		apb(adr_lim, 1'b1, 32'h138);
		wait_step(32'h12C, c);
		check(c, 32'h12C);
		flip <= 1'b1;
		wait_step(32'h12C, c);
		check({31'h0, c < 300}, 32'h1);
		// Clock enable low freezes the loop mid-climb; it resumes once raised
		@(posedge pclk);
		clk_en <= 1'b0;
		@(posedge pclk);
		wait_step(32'h64, c);
		check(c, 32'h64);
		@(posedge pclk);
		clk_en <= 1'b1;
		wait_step(32'h12C, c);
		check({31'h0, c < 300}, 32'h1);
		results;
	end
endmodule // testbench
